// ### rtl/rotate_pkg.sv
// Constants and types shared by the rotate datapath
// Operation
// - left-through-carry: shift left, old carry in, bit7 out
// - left-through-carry result to accumulator only
// - plain right rotate memory, bit0 to bit7
// - plain right rotate into accumulator, memory kept
// - right-through-carry: carry into bit7, bit0 out, memory
package rotate_pkg;
  localparam int DATA_W = 8;
  localparam int MSB_POS = 7;
  localparam int LSB_POS = 0;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic CARRY_RESET = 1'b0;
  localparam int LATENCY_CYCLES = 1;

  // Operation select, Gray-coded along the list order
  typedef enum logic [1:0] {
    OP_ROT_LEFT_THRU_CFLAG_TO_ACCUM = 2'h0,
    OP_ROT_RIGHT_MEM = 2'h1,
    OP_ROT_RIGHT_TO_ACCUM = 2'h3,
    OP_ROT_RIGHT_THRU_CFLAG_MEM = 2'h2
  } rot_op_t;
endpackage

// ### rtl/rot_result_if.sv
// Interface carrying a rotate result from the shifter to the writeback stage
interface rot_result_if;
  import rotate_pkg::*;
  logic [DATA_W-1:0] value;
  logic carryOut;
  logic toAccum;
  logic toMem;
  logic carryWrite;
  modport producer (output value, output carryOut, output toAccum, output toMem,
    output carryWrite);
  modport consumer (input value, input carryOut, input toAccum, input toMem,
    input carryWrite);
endinterface

// ### rtl/rot_shifter.sv
// Combinational one-bit rotate network for all four operations
module rot_shifter
  import rotate_pkg::*;
(
  input wire rot_op_t op,
  input wire logic [DATA_W-1:0] operand,
  input wire logic carryIn,
  rot_result_if.producer res
);
  // Pure function of the operands; destination decode lives here too
  always_comb begin
    res.value = operand;
    res.carryOut = carryIn;
    res.toAccum = 1'b0;
    res.toMem = 1'b0;
    res.carryWrite = 1'b0;
    unique case (op)
      OP_ROT_LEFT_THRU_CFLAG_TO_ACCUM: begin
        res.value = {operand[DATA_W-2:0], carryIn};
        res.carryOut = operand[MSB_POS];
        res.carryWrite = 1'b1;
        res.toAccum = 1'b1;
      end
      OP_ROT_RIGHT_MEM: begin
        res.value = {operand[LSB_POS], operand[DATA_W-1:1]};
        res.toMem = 1'b1;
      end
      OP_ROT_RIGHT_TO_ACCUM: begin
        res.value = {operand[LSB_POS], operand[DATA_W-1:1]};
        res.toAccum = 1'b1;
      end
      OP_ROT_RIGHT_THRU_CFLAG_MEM: begin
        res.value = {carryIn, operand[DATA_W-1:1]};
        res.carryOut = operand[LSB_POS];
        res.carryWrite = 1'b1;
        res.toMem = 1'b1;
      end
    endcase
  end
endmodule

// ### rtl/rotate_unit.sv
// Rotate unit top: accumulator, carry flag and memory writeback port
module rotate_unit
  import rotate_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic opValid,
  input wire rot_op_t op,
  input wire logic [DATA_W-1:0] memData,
  output logic [DATA_W-1:0] accum,
  output logic carryFlag,
  output logic memWrEn,
  output logic [DATA_W-1:0] memWrData,
  output logic done
);
  rot_result_if res ();

  rot_shifter u_shifter (
    .op(op),
    .operand(memData),
    .carryIn(carryFlag),
    .res(res.producer)
  );

  // Accumulator loads only for accumulator-destined ops
  always_ff @(posedge core_clk) begin
    if (srst) begin
      accum <= ACC_RESET;
    end else if (opValid && res.toAccum) begin
      accum <= res.value;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      carryFlag <= CARRY_RESET;
    end else if (opValid && res.carryWrite) begin
      carryFlag <= res.carryOut;
    end
  end

  // Registered writeback; one pulse per memory-destined op
  always_ff @(posedge core_clk) begin
    if (srst) begin
      memWrEn <= 1'b0;
      memWrData <= ACC_RESET;
      done <= 1'b0;
    end else begin
      memWrEn <= opValid && res.toMem;
      done <= opValid;
      if (opValid && res.toMem) begin
        memWrData <= res.value;
      end
    end
  end

  rlc_result_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && op == OP_ROT_LEFT_THRU_CFLAG_TO_ACCUM |=>
    accum == {$past(memData[6:0]), $past(carryFlag)} && carryFlag == $past(memData[7]))
    else $error("left carry rotate wrong");
  rlc_nowrite_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && op == OP_ROT_LEFT_THRU_CFLAG_TO_ACCUM |=> !memWrEn)
    else $error("left carry rotate wrote memory");
  rr_mem_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && op == OP_ROT_RIGHT_MEM |=>
    memWrEn && memWrData == {$past(memData[0]), $past(memData[7:1])})
    else $error("right rotate memory wrong");
  rr_acc_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && op == OP_ROT_RIGHT_TO_ACCUM |=>
    !memWrEn && accum == {$past(memData[0]), $past(memData[7:1])})
    else $error("right rotate accum wrong");
  rrc_mem_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && op == OP_ROT_RIGHT_THRU_CFLAG_MEM |=>
    memWrEn && memWrData == {$past(carryFlag), $past(memData[7:1])}
    && carryFlag == $past(memData[0]))
    else $error("right carry rotate wrong");
  plain_carry_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && (op == OP_ROT_RIGHT_MEM || op == OP_ROT_RIGHT_TO_ACCUM) |=> $stable(carryFlag))
    else $error("plain rotate changed carry");
  mem_acc_keep_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && (op == OP_ROT_RIGHT_MEM || op == OP_ROT_RIGHT_THRU_CFLAG_MEM) |=> $stable(accum))
    else $error("memory op changed accum");
  idle_hold_a: assert property (@(posedge core_clk) disable iff (srst)
    !opValid |=> !memWrEn && !done && $stable(carryFlag) && $stable(accum))
    else $error("idle cycle changed state");
  // accumulator op leaves writeback data alone
  acc_wrdata_keep_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && res.toAccum |=> $stable(memWrData))
    else $error("accum op changed writeback data");
  // every taken op answers with done
  op_done_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid |=> done)
    else $error("taken op gave no done");

  rlc_c: cover property (@(posedge core_clk) opValid && op == OP_ROT_LEFT_THRU_CFLAG_TO_ACCUM);
  rrc_c: cover property (@(posedge core_clk) opValid && op == OP_ROT_RIGHT_THRU_CFLAG_MEM
    && carryFlag);
  b2b_c: cover property (@(posedge core_clk) opValid ##1 opValid);
  // Plain right rotate into the accumulator
  rra_c: cover property (@(posedge core_clk) opValid && op == OP_ROT_RIGHT_TO_ACCUM);
endmodule

// ### dv/data_mem_model.sv
// Data memory byte model feeding the rotate unit
module data_mem_model (
  input wire logic core_clk,
  input wire logic loadEn,
  input wire logic [7:0] loadVal,
  input wire logic memWrEn,
  input wire logic [7:0] memWrData,
  output logic [7:0] memData = 8'h00
);
  // Bench preload wins; writeback lands one edge late
  always @(posedge core_clk) begin
    if (loadEn) begin
      memData <= loadVal;
    end else if (memWrEn) begin
      memData <= memWrData;
    end
  end
endmodule

// ### dv/test_rotate_unit.sv
// Self-checking bench for the rotate unit with a data memory model
module test_rotate_unit
  import rotate_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, srst = 1'b1, opValid = 1'b0, loadEn = 1'b0;
  rot_op_t op = OP_ROT_RIGHT_MEM;
  logic [7:0] loadVal = 8'h00, memData, accum, memWrData;
  logic carryFlag, memWrEn, done;
  int num_errors = 0, n_compared = 0;

  rotate_unit i_rotate_unit (.core_clk(core_clk), .srst(srst), .opValid(opValid),
    .op(op), .memData(memData), .accum(accum), .carryFlag(carryFlag),
    .memWrEn(memWrEn), .memWrData(memWrData), .done(done));
  data_mem_model i_data_mem_model (.core_clk(core_clk), .loadEn(loadEn),
    .loadVal(loadVal), .memWrEn(memWrEn), .memWrData(memWrData), .memData(memData));

  // Free-running core clock
  always #2.5 core_clk = ~core_clk;

  task automatic final_report();
    if (num_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  // Preload memory, pulse one op, check both one-cycle pulses
  task automatic do_op(input rot_op_t o, input logic [7:0] d, input logic we);
    loadEn = 1'b1;
    loadVal = d;
    @(posedge core_clk) #1;
    loadEn = 1'b0;
    opValid = 1'b1;
    op = o;
    @(posedge core_clk) #1;
    opValid = 1'b0;
    chk1(done, 1'b1);
    chk1(memWrEn, we);
    @(posedge core_clk) #1;
    chk1(done, 1'b0);
    chk1(memWrEn, 1'b0);
  endtask

  task automatic t_rrc();
    do_op(OP_ROT_RIGHT_THRU_CFLAG_MEM, 8'h81, 1'b1);
    chk8(memData, 8'h40);
    chk1(carryFlag, 1'b1);
  endtask

  task automatic t_rrc_c();
    do_op(OP_ROT_RIGHT_THRU_CFLAG_MEM, 8'h81, 1'b1);
    chk8(memData, 8'hC0);
    chk1(carryFlag, 1'b1);
  endtask

  // Two ops back to back on one preloaded byte
  task automatic t_b2b();
    loadEn = 1'b1;
    loadVal = 8'h01;
    @(posedge core_clk) #1;
    loadEn = 1'b0;
    opValid = 1'b1;
    op = OP_ROT_RIGHT_TO_ACCUM;
    @(posedge core_clk) #1;
    op = OP_ROT_LEFT_THRU_CFLAG_TO_ACCUM;
    chk8(accum, 8'h80);
    @(posedge core_clk) #1;
    opValid = 1'b0;
    chk8(accum, 8'h02);
    chk1(done, 1'b1);
    @(posedge core_clk) #1;
    chk1(done, 1'b0);
    chk8(memData, 8'h01);
  endtask

  task automatic t_rlc();
    do_op(OP_ROT_LEFT_THRU_CFLAG_TO_ACCUM, 8'h40, 1'b0);
    chk8(accum, 8'h81);
    chk1(carryFlag, 1'b0);
    chk8(memData, 8'h40);
  endtask

  task automatic t_rr();
    do_op(OP_ROT_RIGHT_MEM, 8'h01, 1'b1);
    chk8(memData, 8'h80);
    chk8(memWrData, 8'h80);
    chk8(accum, 8'h81);
    chk1(carryFlag, 1'b0);
  endtask

  task automatic t_rra();
    do_op(OP_ROT_RIGHT_TO_ACCUM, 8'h03, 1'b0);
    chk8(accum, 8'h81);
    chk8(memData, 8'h03);
    chk1(carryFlag, 1'b0);
  endtask

  // Reset, then carry chains from each carry op into the next
  initial begin
    repeat (12) @(posedge core_clk);
    #1 srst = 1'b0;
    t_rrc();
    t_rrc_c();
    t_rlc();
    t_rr();
    t_rra();
    t_b2b();
    final_report();
  end

  // Watchdog well past the expected run of about 30 cycles
  initial begin
    #2000;
    num_errors++;
    final_report();
  end
endmodule
